/* srx_phy_control_regs.v */
// Power-down, clock-recovery and equalizer control bank of the eight-lane serial receiver
`timescale 1ns/1ps
`include "srx_phy_regs.vh"
module srx_phy_control_regs
(
  input  wire                     clock_i,
  input  wire                     rst_n_i,
  input  wire [`SRX_ADDR_W-1:0]   addr_i,
  input  wire [`SRX_DATA_W-1:0]   wr_data_i,
  input  wire                     wr_strobe_i,
  input  wire                     rd_strobe_i,
  output reg  [`SRX_DATA_W-1:0]   rd_data_o,
  input  wire                     sync_request_i,
  output reg                      sync_request_out_o,
  output reg                      sync_out_enable_o,
  output reg                      rx_master_powerdown_o,
  output reg  [`SRX_LANES-1:0]    lane_powerdown_bits_o,
  output reg  [`SRX_LANES-1:0]    lane_phy_powerdown_o,
  output reg                      sync_buffer_powerdown_o,
  output reg  [`SRX_LANES-1:0]    recovery_logic_reset_o,
  output reg                      half_rate_enable_o,
  output reg  [1:0]               division_rate_o,
  output reg                      division_rate_undefined_o,
  output reg  [3:0]               lane0_eq_boost_o,
  output reg  [3:0]               lane1_eq_boost_o,
  output reg                      lane0_eq_manual_o,
  output reg                      lane1_eq_manual_o
);

  wire [7:0]                      receiver_master_powerdown_q;
  wire [7:0]                      lane_pd_q;
  wire [7:0]                      generic_powerdown_q;
  wire [7:0]                      rec_reset_q;
  wire [7:0]                      rec_mode_q;
  wire [7:0]                      eq_q;

  reg                             wr_receiver_master_powerdown;
  reg                             wr_lane_pd;
  reg                             wr_generic_powerdown;
  reg                             wr_rec_reset;
  reg                             wr_rec_mode;
  reg                             wr_eq;

  reg  [`SRX_DATA_W-1:0]          next_rd_data;

  wire                            receiver_master_powerdown_bit;
  wire                            sync_pd_bit;
  wire                            rec_reset_bit;
  wire                            half_rate_bit;
  wire [1:0]                      div_field;
  wire [3:0]                      eq0_field;
  wire [3:0]                      eq1_field;

  reg  [`SRX_LANES-1:0]           next_lane_lane_powerdown_override;
  reg  [`SRX_LANES-1:0]           next_rec_reset;
  reg  [`SRX_LANES-1:0]           lane_active;
  reg                             next_sync_out;
  reg                             next_sync_enable;
  reg                             next_div_undef;
  reg                             next_eq0_manual;
  reg                             next_eq1_manual;

  // Write address decode

  always @*
  begin
    wr_receiver_master_powerdown  = 1'b0;
    wr_lane_pd    = 1'b0;
    wr_generic_powerdown = 1'b0;
    wr_rec_reset  = 1'b0;
    wr_rec_mode   = 1'b0;
    wr_eq         = 1'b0;
    if (wr_strobe_i)
    begin
      if (addr_i == `SRX_ADDR_RECEIVER_MASTER_POWERDOWN)
      begin
        wr_receiver_master_powerdown = 1'b1;
      end
      else if (addr_i == `SRX_ADDR_LANE_PD)
      begin
        wr_lane_pd = 1'b1;
      end
      else if (addr_i == `SRX_ADDR_GENERIC_POWERDOWN)
      begin
        wr_generic_powerdown = 1'b1;
      end
      else if (addr_i == `SRX_ADDR_REC_RESET)
      begin
        wr_rec_reset = 1'b1;
      end
      else if (addr_i == `SRX_ADDR_REC_MODE)
      begin
        wr_rec_mode = 1'b1;
      end
      else if (addr_i == `SRX_ADDR_EQ_LANES_0_1)
      begin
        wr_eq = 1'b1;
      end
    end
  end

  // Register storage

  srx_cfg_reg
  #(
    .RESET_VAL (`SRX_RST_RECEIVER_MASTER_POWERDOWN),
    .WR_MASK   (`SRX_MASK_RECEIVER_MASTER_POWERDOWN)
  )
  u_receiver_master_powerdown
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_receiver_master_powerdown),
    .wr_data_i (wr_data_i),
    .q_o       (receiver_master_powerdown_q)
  ); // [R1]

  srx_cfg_reg
  #(
    .RESET_VAL (`SRX_RST_LANE_PD),
    .WR_MASK   (`SRX_MASK_LANE_PD)
  )
  u_lane_pd
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_lane_pd),
    .wr_data_i (wr_data_i),
    .q_o       (lane_pd_q)
  ); // [R2]

  srx_cfg_reg
  #(
    .RESET_VAL (`SRX_RST_GENERIC_POWERDOWN),
    .WR_MASK   (`SRX_MASK_GENERIC_POWERDOWN)
  )
  u_generic_powerdown
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_generic_powerdown),
    .wr_data_i (wr_data_i),
    .q_o       (generic_powerdown_q)
  ); // [R3]

  srx_cfg_reg
  #(
    .RESET_VAL (`SRX_RST_REC_RESET),
    .WR_MASK   (`SRX_MASK_REC_RESET)
  )
  u_rec_reset
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_rec_reset),
    .wr_data_i (wr_data_i),
    .q_o       (rec_reset_q)
  ); // [R4]

  // Reserved bits of this byte are writable and kept, so software read-modify-write is safe
  srx_cfg_reg
  #(
    .RESET_VAL (`SRX_RST_REC_MODE),
    .WR_MASK   (`SRX_MASK_REC_MODE)
  )
  u_rec_mode
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_rec_mode),
    .wr_data_i (wr_data_i),
    .q_o       (rec_mode_q)
  ); // [R5] [R6]

  srx_cfg_reg
  #(
    .RESET_VAL (`SRX_RST_EQ_LANES_0_1),
    .WR_MASK   (`SRX_MASK_EQ_LANES_0_1)
  )
  u_eq
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (wr_eq),
    .wr_data_i (wr_data_i),
    .q_o       (eq_q)
  ); // [R7]

  // Field extraction

  assign receiver_master_powerdown_bit = receiver_master_powerdown_q[`SRX_BIT_RECEIVER_MASTER_POWERDOWN];
  assign sync_pd_bit   = generic_powerdown_q[`SRX_BIT_SYNC_PD];
  assign rec_reset_bit = rec_reset_q[`SRX_BIT_REC_RESET];
  assign half_rate_bit = rec_mode_q[`SRX_BIT_HALF_RATE];
  assign div_field     = rec_mode_q[`SRX_DIV_HI:`SRX_DIV_LO];
  assign eq0_field     = eq_q[`SRX_EQ0_HI:`SRX_EQ0_LO];
  assign eq1_field     = eq_q[`SRX_EQ1_HI:`SRX_EQ1_LO];

  // Derived lane controls

  always @*
  begin
    // Master power-down overrides every lane bit
    next_lane_lane_powerdown_override = lane_pd_q | {`SRX_LANES{receiver_master_powerdown_bit}}; // [R1] [R2]
    // A lane kept out of power is still held in recovery reset until software releases it
    next_rec_reset   = {`SRX_LANES{rec_reset_bit}}; // [R4]
    lane_active      = ~next_lane_lane_powerdown_override & ~next_rec_reset;
    next_sync_enable = ~sync_pd_bit; // [R3]
    next_sync_out    = sync_request_i & ~sync_pd_bit; // [R3]
    next_div_undef   = (div_field == `SRX_DIV_UNDEF); // [R6]
    next_eq0_manual  = (eq0_field == `SRX_EQ_MANUAL); // [R7]
    next_eq1_manual  = (eq1_field == `SRX_EQ_MANUAL); // [R7]
  end

  // Power-down outputs; reset values equal the register images so nothing glitches on release
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_master_powerdown_o     <= 1'b1;
      lane_powerdown_bits_o     <= `SRX_ZERO_LANES;
      lane_phy_powerdown_o      <= {`SRX_LANES{1'b1}};
    end
    else
    begin
      rx_master_powerdown_o     <= receiver_master_powerdown_bit; // [R1]
      lane_powerdown_bits_o     <= lane_pd_q; // [R2]
      lane_phy_powerdown_o      <= next_lane_lane_powerdown_override; // [R1] [R2]
    end
  end

  // Sync buffer outputs; the request is gated here so a powered-down buffer never toggles
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_buffer_powerdown_o   <= 1'b0;
      sync_out_enable_o         <= 1'b1;
      sync_request_out_o        <= 1'b0;
    end
    else
    begin
      sync_buffer_powerdown_o   <= sync_pd_bit; // [R3]
      sync_out_enable_o         <= next_sync_enable; // [R3]
      sync_request_out_o        <= next_sync_out; // [R3]
    end
  end

  // Recovery reset outputs
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      recovery_logic_reset_o    <= {`SRX_LANES{1'b1}};
    end
    else
    begin
      recovery_logic_reset_o    <= next_rec_reset; // [R4]
    end
  end

  // Recovery mode outputs; code 3 is passed on and flagged rather than remapped
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      half_rate_enable_o        <= 1'b1;
      division_rate_o           <= `SRX_DIV_NONE;
      division_rate_undefined_o <= 1'b0;
    end
    else
    begin
      half_rate_enable_o        <= half_rate_bit; // [R5]
      division_rate_o           <= div_field; // [R6]
      division_rate_undefined_o <= next_div_undef; // [R6]
    end
  end

  // Equalizer outputs
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lane0_eq_boost_o          <= `SRX_RST_EQ_BOOST;
      lane1_eq_boost_o          <= `SRX_RST_EQ_BOOST;
      lane0_eq_manual_o         <= 1'b0;
      lane1_eq_manual_o         <= 1'b0;
    end
    else
    begin
      lane0_eq_boost_o          <= eq0_field; // [R7]
      lane1_eq_boost_o          <= eq1_field; // [R7]
      lane0_eq_manual_o         <= next_eq0_manual; // [R7]
      lane1_eq_manual_o         <= next_eq1_manual; // [R7]
    end
  end

  // Read address decode; unmapped addresses read zero

  always @*
  begin
    next_rd_data = `SRX_ZERO_BYTE;
    if (rd_strobe_i)
    begin
      if (addr_i == `SRX_ADDR_RECEIVER_MASTER_POWERDOWN)
      begin
        next_rd_data = receiver_master_powerdown_q; // [R8]
      end
      else if (addr_i == `SRX_ADDR_LANE_PD)
      begin
        next_rd_data = lane_pd_q;
      end
      else if (addr_i == `SRX_ADDR_GENERIC_POWERDOWN)
      begin
        next_rd_data = generic_powerdown_q; // [R8]
      end
      else if (addr_i == `SRX_ADDR_REC_RESET)
      begin
        next_rd_data = rec_reset_q; // [R8]
      end
      else if (addr_i == `SRX_ADDR_LANE_STATUS)
      begin
        next_rd_data = lane_active;
      end
      else if (addr_i == `SRX_ADDR_REC_MODE)
      begin
        next_rd_data = rec_mode_q;
      end
      else if (addr_i == `SRX_ADDR_EQ_LANES_0_1)
      begin
        next_rd_data = eq_q;
      end
    end
  end

  // Read data stands for exactly the cycle after the strobe, zero otherwise
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= `SRX_ZERO_BYTE;
    end
    else
    begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule // srx_phy_control_regs

/* srx_phy_regs.vh */
// Register map, reset values and field positions of the receiver front-end control bank
// How it works
// [R1] Master bit powers down the receiver and every lane, but not the sync buffer
// [R2] Override bit n powers down lane n
// [R3] Generic bit 1 powers down sync buffer
// [R4] Recovery reset bit holds all lane recovery
// [R5] Bit 5 selects half-rate recovery, resets one
// [R6] Division field picks oversampling, resets zero
// [R7] Equalizer nibble zero means manual, else boost
// [R8] Read-only reserved bits read zero, ignore writes
`ifndef SRX_PHY_REGS_VH
`define SRX_PHY_REGS_VH

`define SRX_ADDR_W            10
`define SRX_DATA_W            8
`define SRX_LANES             8

`define SRX_ADDR_RECEIVER_MASTER_POWERDOWN    10'h200
`define SRX_ADDR_LANE_PD      10'h201
`define SRX_ADDR_GENERIC_POWERDOWN   10'h203
`define SRX_ADDR_REC_RESET    10'h206
`define SRX_ADDR_LANE_STATUS  10'h207
`define SRX_ADDR_REC_MODE     10'h230
`define SRX_ADDR_EQ_LANES_0_1 10'h250

`define SRX_RST_RECEIVER_MASTER_POWERDOWN     8'h01
`define SRX_RST_LANE_PD       8'h00
`define SRX_RST_GENERIC_POWERDOWN    8'h00
`define SRX_RST_REC_RESET     8'h01
`define SRX_RST_REC_MODE      8'h28
`define SRX_RST_EQ_LANES_0_1  8'h88

`define SRX_MASK_RECEIVER_MASTER_POWERDOWN    8'h01
`define SRX_MASK_LANE_PD      8'hff
`define SRX_MASK_GENERIC_POWERDOWN   8'h03
`define SRX_MASK_REC_RESET    8'h01
`define SRX_MASK_REC_MODE     8'hff
`define SRX_MASK_EQ_LANES_0_1 8'hff

`define SRX_BIT_RECEIVER_MASTER_POWERDOWN     0
`define SRX_BIT_SYNC_PD       1
`define SRX_BIT_REC_RESET     0
`define SRX_BIT_HALF_RATE     5
`define SRX_DIV_HI            2
`define SRX_DIV_LO            1
`define SRX_EQ0_HI            3
`define SRX_EQ0_LO            0
`define SRX_EQ1_HI            7
`define SRX_EQ1_LO            4

`define SRX_DIV_NONE          2'h0
`define SRX_DIV_BY2           2'h1
`define SRX_DIV_BY4           2'h2
`define SRX_DIV_UNDEF         2'h3
`define SRX_EQ_MANUAL         4'h0
`define SRX_RST_EQ_BOOST      4'h8

`define SRX_ZERO_BYTE         8'h00
`define SRX_ZERO_LANES        8'h00

`endif

/* srx_cfg_reg.v */
// One byte-wide configuration register with a write mask and a fixed reset value
`timescale 1ns/1ps
module srx_cfg_reg
#(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WR_MASK   = 8'hff
)
(
  input  wire       clock_i,
  input  wire       rst_n_i,
  input  wire       wr_en_i,
  input  wire [7:0] wr_data_i,
  output reg  [7:0] q_o
);

  wire [7:0] next_q;

  // Masked bits keep their reset value forever, so read-only reserved bits stay zero
  assign next_q = (q_o & ~WR_MASK) | (wr_data_i & WR_MASK); // [R8]

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_o <= RESET_VAL;
    end
    else if (wr_en_i)
    begin
      q_o <= next_q;
    end
  end

endmodule // srx_cfg_reg

/* srx_phy_control_regs_asserts.sv */
// Checker for the receiver control bank ports
`timescale 1ns/1ps
`include "srx_phy_regs.vh"
module srx_phy_control_regs_asserts
(
  input wire                   clock_i,
  input wire                   rst_n_i,
  input wire [`SRX_ADDR_W-1:0] addr_i,
  input wire [7:0]             wr_data_i,
  input wire                   wr_strobe_i,
  input wire                   rd_strobe_i,
  input wire [7:0]             rd_data_o,
  input wire                   sync_request_i,
  input wire                   sync_request_out_o,
  input wire                   sync_buffer_powerdown_o,
  input wire                   rx_master_powerdown_o,
  input wire [7:0]             lane_powerdown_bits_o,
  input wire [7:0]             lane_phy_powerdown_o,
  input wire [7:0]             recovery_logic_reset_o,
  input wire                   half_rate_enable_o,
  input wire [1:0]             division_rate_o,
  input wire [3:0]             lane1_eq_boost_o,
  input wire                   lane1_eq_manual_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Outputs lag the stored byte by one edge, so the write shows two edges on
  sequence s_wr(a);
    wr_strobe_i && addr_i == a;
  endsequence
  a_master_all: assert property (rx_master_powerdown_o |-> lane_phy_powerdown_o == 8'hff)
    else $error("master powerdown left a lane up");
  a_lane_map: assert property (lane_phy_powerdown_o == (lane_powerdown_bits_o | {8{rx_master_powerdown_o}}))
    else $error("lane powerdown mapping wrong");
  a_sync_gate: assert property (sync_buffer_powerdown_o && $past(sync_buffer_powerdown_o) |-> !sync_request_out_o)
    else $error("sync output driven while buffer down");
  a_sync_follow: assert property (!sync_buffer_powerdown_o && $past(rst_n_i) ##1 !sync_buffer_powerdown_o
    |-> sync_request_out_o == $past(sync_request_i))
    else $error("sync output not one cycle behind");
  a_rec_all: assert property (s_wr(`SRX_ADDR_REC_RESET) |=> ##1 recovery_logic_reset_o == {8{$past(wr_data_i[0], 2)}})
    else $error("recovery reset not applied to all lanes");
  a_half_rate: assert property (s_wr(`SRX_ADDR_REC_MODE) |=> ##1 half_rate_enable_o == $past(wr_data_i[5], 2))
    else $error("half rate select wrong");
  a_div_rate: assert property (s_wr(`SRX_ADDR_REC_MODE) |=> ##1 division_rate_o == $past(wr_data_i[2:1], 2))
    else $error("division field wrong");
  a_eq_manual: assert property (s_wr(`SRX_ADDR_EQ_LANES_0_1) |=> ##1 lane1_eq_boost_o == $past(wr_data_i[7:4], 2)
    && lane1_eq_manual_o == ($past(wr_data_i[7:4], 2) == 4'h0))
    else $error("lane one equalizer wrong");
  a_rsvd_zero: assert property (rd_strobe_i && addr_i == `SRX_ADDR_RECEIVER_MASTER_POWERDOWN |=> rd_data_o[7:1] == 7'h00)
    else $error("reserved bits read nonzero");
  a_rd_idle: assert property (!$past(rd_strobe_i) |-> rd_data_o == 8'h00)
    else $error("read data outside its cycle");
endmodule // srx_phy_control_regs_asserts
bind srx_phy_control_regs srx_phy_control_regs_asserts srx_phy_control_regs_asserts_i (.*);

/* srx_sync_source.sv */
// Far-side sync request source
`timescale 1ns/1ps
module srx_sync_source
(
  input  wire clock_i,
  input  wire rst_n_i,
  input  wire enable_i,
  output reg  sync_request_o
);
  // Toggles each cycle while enable_i is high, so a stuck or late output shows at once
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_request_o <= 1'b0;
    else
      sync_request_o <= enable_i & ~sync_request_o;
  end
endmodule // srx_sync_source

/* srx_phy_control_regs_tb.sv */
// Self-checking bench for the receiver control bank
`timescale 1ns/1ps
module srx_phy_control_regs_tb;
  reg        clock_i;
  reg        rst_n_i;
  reg  [9:0] addr_i;
  reg  [7:0] wr_data_i;
  reg        wr_strobe_i;
  reg        rd_strobe_i;
  reg        src_on;
  integer    error_cnt;
  integer    tests_run;
  integer    n;
  wire       sync_request_i;
  wire       sync_request_out_o, sync_out_enable_o, rx_master_powerdown_o, sync_buffer_powerdown_o;
  wire       half_rate_enable_o, division_rate_undefined_o, lane0_eq_manual_o, lane1_eq_manual_o;
  wire [7:0] rd_data_o, lane_powerdown_bits_o, lane_phy_powerdown_o, recovery_logic_reset_o;
  wire [1:0] division_rate_o;
  wire [3:0] lane0_eq_boost_o, lane1_eq_boost_o;
  srx_phy_control_regs srx_phy_control_regs_i (.*);
  srx_sync_source srx_sync_source_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(src_on),
    .sync_request_o(sync_request_i));
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    begin
      @(posedge clock_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_strobe_i <= 1'b1;
      @(posedge clock_i);
      wr_strobe_i <= 1'b0;
    end
  endtask
  task rchk(input [9:0] a, input [7:0] e);
    begin
      @(posedge clock_i);
      addr_i <= a;
      rd_strobe_i <= 1'b1;
      @(posedge clock_i);
      rd_strobe_i <= 1'b0;
      #1 chk(rd_data_o, e);
    end
  endtask
  // Derived outputs need one more edge after the write
  task settle;
    begin
      repeat (2) @(posedge clock_i);
      #1;
    end
  endtask
  task t_reset;
    begin
      rchk(10'h200, 8'h01);
      rchk(10'h201, 8'h00);
      rchk(10'h203, 8'h00);
      rchk(10'h206, 8'h01);
      rchk(10'h230, 8'h28);
      rchk(10'h250, 8'h88);
      chk(recovery_logic_reset_o, 8'hff);
      chk({3'h0, half_rate_enable_o, 2'h0, division_rate_o}, 8'h10);
      chk({lane1_eq_boost_o, lane0_eq_boost_o}, 8'h88);
      wr(10'h3ff, 8'hff);
      rchk(10'h3ff, 8'h00);
    end
  endtask
  task t_power;
    begin
      wr(10'h200, 8'h00);
      settle;
      chk({7'h0, rx_master_powerdown_o}, 8'h00);
      chk(lane_phy_powerdown_o, 8'h00);
      wr(10'h200, 8'hff);
      rchk(10'h200, 8'h01);
      chk({7'h0, rx_master_powerdown_o}, 8'h01);
      chk(lane_phy_powerdown_o, 8'hff);
      wr(10'h201, 8'h5a);
      settle;
      chk(lane_powerdown_bits_o, 8'h5a);
      chk(lane_phy_powerdown_o, 8'hff);
      wr(10'h200, 8'h00);
      for (n = 0; n < 8; n = n + 1)
      begin
        wr(10'h201, 8'h01 << n);
        rchk(10'h201, 8'h01 << n);
        chk(lane_phy_powerdown_o, 8'h01 << n);
        chk(lane_powerdown_bits_o, 8'h01 << n);
      end
    end
  endtask
  task t_sync;
    begin
      src_on <= 1'b1;
      settle;
      chk({7'h0, sync_request_out_o}, {7'h0, ~sync_request_i});
      chk({6'h0, sync_buffer_powerdown_o, sync_out_enable_o}, 8'h01);
      wr(10'h203, 8'hff);
      settle;
      rchk(10'h203, 8'h03);
      chk({5'h0, sync_buffer_powerdown_o, sync_request_out_o, sync_out_enable_o}, 8'h04);
      @(posedge clock_i);
      #1 chk({7'h0, sync_request_out_o}, 8'h00);
      wr(10'h203, 8'h00);
      src_on <= 1'b0;
    end
  endtask
  task t_rec;
    begin
      wr(10'h206, 8'hfe);
      settle;
      chk(recovery_logic_reset_o, 8'h00);
      rchk(10'h206, 8'h00);
      rchk(10'h207, 8'h7f);
      wr(10'h207, 8'h00);
      rchk(10'h207, 8'h7f);
      wr(10'h206, 8'h01);
      settle;
      chk(recovery_logic_reset_o, 8'hff);
      rchk(10'h207, 8'h00);
    end
  endtask
  task t_mode;
    begin
      for (n = 0; n < 4; n = n + 1)
      begin
        wr(10'h230, {2'b00, n[0], 2'b01, n[1:0], 1'b0});
        settle;
        chk({5'h0, half_rate_enable_o, division_rate_o}, {5'h0, n[0], n[1:0]});
        chk({7'h0, division_rate_undefined_o}, (n == 3) ? 8'h01 : 8'h00);
      end
    end
  endtask
  task t_eq;
    begin
      wr(10'h250, 8'h05);
      settle;
      chk({lane1_eq_boost_o, 2'b00, lane1_eq_manual_o, lane0_eq_manual_o}, 8'h02);
      chk({lane0_eq_boost_o, 4'h0}, 8'h50);
      wr(10'h250, 8'hf0);
      settle;
      chk({lane1_eq_boost_o, 2'b00, lane1_eq_manual_o, lane0_eq_manual_o}, 8'hf1);
      chk({lane0_eq_boost_o, 4'h0}, 8'h00);
      rchk(10'h250, 8'hf0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    addr_i = 10'h000;
    wr_data_i = 8'h00;
    wr_strobe_i = 1'b0;
    rd_strobe_i = 1'b0;
    src_on = 1'b0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_power;
    t_sync;
    t_rec;
    t_mode;
    t_eq;
    tally_and_finish;
  end
endmodule // srx_phy_control_regs_tb
